// ### hdl/fpsc_pkg.sv
package fpsc_pkg;
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned RECOVER_RESET_NS = 500000;
	localparam int unsigned RECOVER_RESET_CYC = (RECOVER_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned READ_WAIT_NS = 2000000;
	localparam int unsigned READ_WAIT_CYC = (READ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned KEY_WINDOW_CYC = 16;
	// Device register map and fields
	localparam int unsigned NUM_BLOCKS = 10;
	localparam logic [7:0] SEC_ENABLE_OFS = 8'h10;
	localparam logic [7:0] PROTECT_STATUS_OFS = 8'h20;
	localparam int unsigned PROT_LSB = 16;
	localparam int unsigned READY_BIT = 0;
	localparam int unsigned SEC_BIT = 0;
	localparam logic SEC_RST = 1'b1;
	localparam logic [31:0] SEC_KEY = 32'hA74A9D23;
	// Controller register map and fields
	localparam logic [7:0] H_CMD_OFS = 8'h00;
	localparam logic [7:0] H_ADDR_OFS = 8'h04;
	localparam logic [7:0] H_WDATA_OFS = 8'h08;
	localparam logic [7:0] H_CTRL_OFS = 8'h0C;
	localparam logic [7:0] H_RDATA_OFS = 8'h10;
	localparam logic [7:0] H_STATUS_OFS = 8'h14;
	localparam logic [7:0] H_RESET_OFS = 8'h18;
	localparam int unsigned CMD_BLK_LSB = 0;
	localparam int unsigned CMD_OP_LSB = 8;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_WE = 1;
	localparam int unsigned CTRL_FULL32 = 2;
	localparam int unsigned CTRL_KEYED = 3;
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_READY = 1;
	localparam int unsigned ST_REFUSED = 2;
	localparam int unsigned ST_READ_OK = 3;
	localparam int unsigned ST_IN_RESET = 4;
	localparam int unsigned RST_GO = 0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Flash commands and states
	typedef enum logic [1:0] {
		FPSC_OP_PROG = 2'b00,
		FPSC_OP_ERASE = 2'b01,
		FPSC_OP_PROT_PROG = 2'b10,
		FPSC_OP_PROT_ERASE = 2'b11
	} fpsc_op_e;
	typedef enum logic [1:0] {
		DEV_READY = 2'b00,
		DEV_BUSY = 2'b01,
		DEV_FAILED = 2'b10
	} fpsc_dev_state_e;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_KEY = 3'b001,
		H_KEY_WAIT = 3'b010,
		H_ACC = 3'b011,
		H_ACC_WAIT = 3'b100
	} fpsc_host_state_e;
endpackage : fpsc_pkg

// ### hdl/fpsc_if.sv
interface fpsc_if;
	import fpsc_pkg::*;
	// Recovery reset from the controller, active low
	logic sys_rstn;
	// Register access
	logic req;
	logic we;
	logic full32;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	// Flash commands
	logic cmd_valid;
	fpsc_op_e cmd_op;
	logic [3:0] cmd_block;
	// Status
	logic ready_flag;
	logic read_ok;

	modport dev (
		input sys_rstn, req, we, full32, addr, wdata, cmd_valid, cmd_op, cmd_block,
		output rdata, ack, ready_flag, read_ok
	);
	modport host (
		output sys_rstn, req, we, full32, addr, wdata, cmd_valid, cmd_op, cmd_block,
		input rdata, ack, ready_flag, read_ok
	);
endinterface : fpsc_if

// ### hdl/fpsc_key_window.sv
module fpsc_key_window #(
	parameter int unsigned WINDOW = fpsc_pkg::KEY_WINDOW_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Events
	input wire logic arm,
	input wire logic consume,
	// Window state
	output logic open
);
	import fpsc_pkg::*;
	localparam int unsigned CW = $clog2(WINDOW + 1);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	////////////////////////////////////////////////////////////////
	// A fresh key rearms the window; the data write closes it so it cannot be reused
	always_comb begin
		nxt_cnt = cnt_ff;
		if (arm) begin
			nxt_cnt = CW'(WINDOW);
		end else if (consume) begin
			nxt_cnt = '0;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - CW'(1);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign open = (cnt_ff != '0);
endmodule : fpsc_key_window

// ### hdl/fpsc_device.sv
// Overview of operation
// - Ten read-only protection flags at bits 25-16
// - Data writes to protected blocks are refused
// - Ready flag low while automatic operation runs
// - Successful completion returns ready flag high
// - Failed operation holds flag low until reset
// - Controller issues commands only when ready
// - Command while busy locks command input
// - Recovery reset held at least 0.5 ms
// - Reads possible about 2 ms after reset
// - Security bit at bit 0, one at reset
// - Security bit reloaded on deepest standby release
// - Protection flags programmed one block at a time
// - Protection erase clears all flags together
// - Protection changed only through flash commands
// - Protection commands work in all boot modes
// - Key then data within 16 clocks
// - Keyed rewrite needs 32-bit transfers
// - Security active when bit and all flags set
// - Active security blocks debug, trace, all commands but protection erase
module fpsc_device #(
	parameter int unsigned READ_WAIT = fpsc_pkg::READ_WAIT_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Link to the controller
	fpsc_if.dev bus,
	// Flash array side
	input wire logic standby_release,
	input wire logic [fpsc_pkg::NUM_BLOCKS-1:0] prot_init,
	input wire logic op_done,
	input wire logic op_fail,
	output logic op_start,
	output fpsc_pkg::fpsc_op_e op_kind,
	output logic [3:0] op_block,
	// Security and status
	output logic security_active,
	output logic debug_block,
	output logic trace_block,
	output logic cmd_refused,
	output logic cmd_lockup
);
	import fpsc_pkg::*;
	localparam int unsigned RW = $clog2(READ_WAIT + 1);

	logic rst_n;
	logic sec_wr;
	logic key_hit;
	logic win_open;
	fpsc_dev_state_e st_ff, nxt_st;
	logic [NUM_BLOCKS-1:0] prot_ff, nxt_prot;
	logic loaded_ff, nxt_loaded;
	logic blocked_ff, nxt_blocked;
	logic sec_ff, nxt_sec;
	logic secact_ff, nxt_secact;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [RW-1:0] rdcnt_ff, nxt_rdcnt;
	logic refused_ff, nxt_refused;
	logic start_ff, nxt_start;
	fpsc_op_e kind_ff, nxt_kind;
	logic [3:0] blk_ff, nxt_blk;

	////////////////////////////////////////////////////////////////
	// Either the pin reset or the controller's recovery reset clears the block
	assign rst_n = rstn & bus.sys_rstn;
	// Only full-word writes count toward the keyed sequence
	assign sec_wr = bus.req & bus.we & bus.full32 & (bus.addr == SEC_ENABLE_OFS);
	assign key_hit = sec_wr & (bus.wdata == SEC_KEY);

	fpsc_key_window #(
		.WINDOW(KEY_WINDOW_CYC)
	) u_key_window (
		.clock(clock),
		.rstn(rst_n),
		.arm(key_hit),
		.consume(sec_wr & ~key_hit),
		.open(win_open)
	);

	////////////////////////////////////////////////////////////////
	// Register reads, security bit, command acceptance and operation tracking
	always_comb begin
		nxt_st = st_ff;
		nxt_prot = prot_ff;
		nxt_loaded = 1'b1;
		nxt_blocked = blocked_ff;
		nxt_sec = sec_ff;
		nxt_ack = bus.req;
		nxt_rdata = rdata_ff;
		nxt_rdcnt = rdcnt_ff;
		nxt_refused = 1'b0;
		nxt_start = 1'b0;
		nxt_kind = kind_ff;
		nxt_blk = blk_ff;
		// Flags live in the array; they are sampled once after reset is released
		if (!loaded_ff) begin
			nxt_prot = prot_init;
		end
		// Flash reads wait for the array to settle after any reset
		if (rdcnt_ff != '0) begin
			nxt_rdcnt = rdcnt_ff - RW'(1);
		end
		// Register read data; every unused bit stays zero
		if (bus.req && !bus.we) begin
			nxt_rdata = '0;
			case (bus.addr)
				SEC_ENABLE_OFS: begin
					nxt_rdata[SEC_BIT] = sec_ff;
				end
				PROTECT_STATUS_OFS: begin
					nxt_rdata[PROT_LSB +: NUM_BLOCKS] = prot_ff;
					nxt_rdata[READY_BIT] = (st_ff == DEV_READY);
				end
				default: begin
					nxt_rdata = '0;
				end
			endcase
		end
		// Security bit changes only inside the key window or on standby release; status writes are ignored
		if (standby_release) begin
			nxt_sec = SEC_RST;
		end else if (sec_wr && !key_hit && win_open) begin
			nxt_sec = bus.wdata[SEC_BIT];
		end
		// Automatic operation completion
		if (st_ff == DEV_BUSY && op_done) begin
			if (op_fail) begin
				nxt_st = DEV_FAILED;
			end else begin
				nxt_st = DEV_READY;
				case (kind_ff)
					FPSC_OP_PROT_PROG: begin
						nxt_prot[blk_ff] = 1'b1;
					end
					FPSC_OP_PROT_ERASE: begin
						nxt_prot = '0;
					end
					default: begin
						nxt_prot = nxt_prot;
					end
				endcase
			end
		end
		// Command acceptance; protection erase stays open under security
		if (bus.cmd_valid) begin
			if (st_ff != DEV_READY) begin
				nxt_blocked = 1'b1;
				nxt_refused = 1'b1;
			end else if (blocked_ff) begin
				nxt_refused = 1'b1;
			end else if (secact_ff && bus.cmd_op != FPSC_OP_PROT_ERASE) begin
				nxt_refused = 1'b1;
			end else if (bus.cmd_block >= 4'(NUM_BLOCKS) && bus.cmd_op != FPSC_OP_PROT_ERASE) begin
				nxt_refused = 1'b1;
			end else if ((bus.cmd_op == FPSC_OP_PROG || bus.cmd_op == FPSC_OP_ERASE)
					&& prot_ff[bus.cmd_block]) begin
				nxt_refused = 1'b1;
			end else begin
				nxt_st = DEV_BUSY;
				nxt_start = 1'b1;
				nxt_kind = bus.cmd_op;
				nxt_blk = bus.cmd_block;
			end
		end
		nxt_secact = nxt_sec & (&nxt_prot);
	end

	// Security bit resets high; flags are cleared until the array is sampled
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= DEV_READY;
			prot_ff <= '0;
			loaded_ff <= 1'b0;
			blocked_ff <= 1'b0;
			sec_ff <= SEC_RST;
			secact_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdata_ff <= '0;
			rdcnt_ff <= RW'(READ_WAIT);
			refused_ff <= 1'b0;
			start_ff <= 1'b0;
			kind_ff <= FPSC_OP_PROG;
			blk_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			prot_ff <= nxt_prot;
			loaded_ff <= nxt_loaded;
			blocked_ff <= nxt_blocked;
			sec_ff <= nxt_sec;
			secact_ff <= nxt_secact;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			rdcnt_ff <= nxt_rdcnt;
			refused_ff <= nxt_refused;
			start_ff <= nxt_start;
			kind_ff <= nxt_kind;
			blk_ff <= nxt_blk;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign bus.ack = ack_ff;
	assign bus.rdata = rdata_ff;
	assign bus.ready_flag = (st_ff == DEV_READY);
	assign bus.read_ok = (rdcnt_ff == '0);
	assign op_start = start_ff;
	assign op_kind = kind_ff;
	assign op_block = blk_ff;
	assign security_active = secact_ff;
	assign debug_block = secact_ff;
	assign trace_block = secact_ff;
	assign cmd_refused = refused_ff;
	assign cmd_lockup = blocked_ff;
endmodule : fpsc_device

// ### hdl/fpsc_host.sv
// Implementation choices: register access over AXI4-Lite and the address map.
module fpsc_host #(
	parameter int unsigned RECOVER = fpsc_pkg::RECOVER_RESET_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Link to the device
	fpsc_if.host bus,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import fpsc_pkg::*;
	localparam int unsigned CW = $clog2(RECOVER + 1);

	function automatic logic [31:0] fpsc_merge(input logic [31:0] old, input logic [31:0] val,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = val[8*i +: 8];
			end
		end
		return res;
	endfunction : fpsc_merge

	function automatic logic fpsc_mapped(input logic [7:0] a);
		return (a == H_CMD_OFS) || (a == H_ADDR_OFS) || (a == H_WDATA_OFS) || (a == H_CTRL_OFS)
			|| (a == H_RDATA_OFS) || (a == H_STATUS_OFS) || (a == H_RESET_OFS);
	endfunction : fpsc_mapped

	logic wr_take;
	logic rd_take;
	logic [31:0] st_word;
	logic [31:0] addr_mrg;
	fpsc_host_state_e st_ff, nxt_st;
	logic [7:0] addr_ff, nxt_addr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [31:0] rdata_ff, nxt_rdata;
	logic we_ff, nxt_we;
	logic full_ff, nxt_full;
	logic [7:0] o_addr_ff, nxt_o_addr;
	logic [31:0] o_wdata_ff, nxt_o_wdata;
	logic o_we_ff, nxt_o_we;
	logic o_full_ff, nxt_o_full;
	logic refused_ff, nxt_refused;
	logic cmd_v_ff, nxt_cmd_v;
	fpsc_op_e cmd_op_ff, nxt_cmd_op;
	logic [3:0] cmd_blk_ff, nxt_cmd_blk;
	logic [CW-1:0] rstcnt_ff, nxt_rstcnt;
	logic sysrstn_ff, nxt_sysrstn;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] axi_rd_ff, nxt_axi_rd;
	logic [1:0] rresp_ff, nxt_rresp;

	////////////////////////////////////////////////////////////////
	// Address and data are taken together so a write never waits half-done
	assign wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
	assign rd_take = s_axi_arvalid & ~rvalid_ff;
	// The address register is one byte wide; only the low lane of the merge is kept
	assign addr_mrg = fpsc_merge({24'h000000, addr_ff}, s_axi_wdata, s_axi_wstrb);

	always_comb begin
		st_word = '0;
		st_word[ST_BUSY] = (st_ff != H_IDLE);
		st_word[ST_READY] = bus.ready_flag;
		st_word[ST_REFUSED] = refused_ff;
		st_word[ST_READ_OK] = bus.read_ok;
		st_word[ST_IN_RESET] = ~sysrstn_ff;
	end

	////////////////////////////////////////////////////////////////
	// Software registers, command issue, access sequencer and recovery reset
	always_comb begin
		nxt_st = st_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_we = we_ff;
		nxt_full = full_ff;
		nxt_o_addr = o_addr_ff;
		nxt_o_wdata = o_wdata_ff;
		nxt_o_we = o_we_ff;
		nxt_o_full = o_full_ff;
		nxt_refused = refused_ff;
		nxt_cmd_v = 1'b0;
		nxt_cmd_op = cmd_op_ff;
		nxt_cmd_blk = cmd_blk_ff;
		nxt_rstcnt = (rstcnt_ff != '0) ? rstcnt_ff - CW'(1) : rstcnt_ff;
		nxt_bvalid = bvalid_ff & ~s_axi_bready;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff & ~s_axi_rready;
		nxt_axi_rd = axi_rd_ff;
		nxt_rresp = rresp_ff;
		// Access sequencer; the key is sent first so the data lands inside the window
		case (st_ff)
			H_KEY: nxt_st = H_KEY_WAIT;
			H_KEY_WAIT: begin
				if (bus.ack) begin
					nxt_st = H_ACC;
					nxt_o_addr = addr_ff;
					nxt_o_wdata = wdata_ff;
					nxt_o_we = we_ff;
					nxt_o_full = full_ff;
				end
			end
			H_ACC: nxt_st = H_ACC_WAIT;
			H_ACC_WAIT: begin
				if (bus.ack) begin
					nxt_st = H_IDLE;
					if (!o_we_ff) begin
						nxt_rdata = bus.rdata;
					end
				end
			end
			default: nxt_st = H_IDLE;
		endcase
		if (wr_take) begin
			nxt_bvalid = 1'b1;
			nxt_bresp = fpsc_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_awaddr)
				H_CMD_OFS: begin
					// Commands only go out while the device reports ready
					if (bus.ready_flag && sysrstn_ff) begin
						nxt_cmd_v = 1'b1;
						nxt_cmd_op = fpsc_op_e'(s_axi_wdata[CMD_OP_LSB +: 2]);
						nxt_cmd_blk = s_axi_wdata[CMD_BLK_LSB +: 4];
					end else begin
						nxt_refused = 1'b1;
					end
				end
				H_ADDR_OFS: nxt_addr = addr_mrg[7:0];
				H_WDATA_OFS: nxt_wdata = fpsc_merge(wdata_ff, s_axi_wdata, s_axi_wstrb);
				H_CTRL_OFS: begin
					if (st_ff == H_IDLE && sysrstn_ff && s_axi_wdata[CTRL_START]) begin
						nxt_we = s_axi_wdata[CTRL_WE];
						nxt_full = s_axi_wdata[CTRL_FULL32];
						if (s_axi_wdata[CTRL_KEYED]) begin
							nxt_st = H_KEY;
							nxt_o_addr = SEC_ENABLE_OFS;
							nxt_o_wdata = SEC_KEY;
							nxt_o_we = 1'b1;
							nxt_o_full = 1'b1;
						end else begin
							nxt_st = H_ACC;
							nxt_o_addr = addr_ff;
							nxt_o_wdata = wdata_ff;
							nxt_o_we = s_axi_wdata[CTRL_WE];
							nxt_o_full = s_axi_wdata[CTRL_FULL32];
						end
					end
				end
				H_STATUS_OFS: begin
					if (s_axi_wdata[ST_REFUSED]) begin
						nxt_refused = 1'b0;
					end
				end
				H_RESET_OFS: begin
					if (s_axi_wdata[RST_GO]) begin
						nxt_rstcnt = CW'(RECOVER);
					end
				end
				default: nxt_bresp = nxt_bresp;
			endcase
		end
		if (rd_take) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = fpsc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				H_ADDR_OFS: nxt_axi_rd = {24'h000000, addr_ff};
				H_WDATA_OFS: nxt_axi_rd = wdata_ff;
				H_RDATA_OFS: nxt_axi_rd = rdata_ff;
				H_STATUS_OFS: nxt_axi_rd = st_word;
				default: nxt_axi_rd = '0;
			endcase
		end
		// An access cut by the recovery reset would never be acknowledged
		nxt_sysrstn = (nxt_rstcnt == '0);
		if (!sysrstn_ff) begin
			nxt_st = H_IDLE;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_ff <= H_IDLE;
			addr_ff <= '0;
			wdata_ff <= '0;
			rdata_ff <= '0;
			we_ff <= 1'b0;
			full_ff <= 1'b0;
			o_addr_ff <= '0;
			o_wdata_ff <= '0;
			o_we_ff <= 1'b0;
			o_full_ff <= 1'b0;
			refused_ff <= 1'b0;
			cmd_v_ff <= 1'b0;
			cmd_op_ff <= FPSC_OP_PROG;
			cmd_blk_ff <= '0;
			rstcnt_ff <= '0;
			sysrstn_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			axi_rd_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else begin
			st_ff <= nxt_st;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			we_ff <= nxt_we;
			full_ff <= nxt_full;
			o_addr_ff <= nxt_o_addr;
			o_wdata_ff <= nxt_o_wdata;
			o_we_ff <= nxt_o_we;
			o_full_ff <= nxt_o_full;
			refused_ff <= nxt_refused;
			cmd_v_ff <= nxt_cmd_v;
			cmd_op_ff <= nxt_cmd_op;
			cmd_blk_ff <= nxt_cmd_blk;
			rstcnt_ff <= nxt_rstcnt;
			sysrstn_ff <= nxt_sysrstn;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			axi_rd_ff <= nxt_axi_rd;
			rresp_ff <= nxt_rresp;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign bus.sys_rstn = sysrstn_ff;
	assign bus.req = (st_ff == H_KEY) || (st_ff == H_ACC);
	assign bus.we = o_we_ff;
	assign bus.full32 = o_full_ff;
	assign bus.addr = o_addr_ff;
	assign bus.wdata = o_wdata_ff;
	assign bus.cmd_valid = cmd_v_ff;
	assign bus.cmd_op = cmd_op_ff;
	assign bus.cmd_block = cmd_blk_ff;
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = axi_rd_ff;
	assign s_axi_rresp = rresp_ff;
endmodule : fpsc_host

// ### sim/fpsc_sva.sv
//////////////////////////////////////////////////////////////////////////////
module fpsc_sva #(
	parameter int unsigned READ_WAIT = 30,
	parameter int unsigned RECOVER = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Link signals
	input wire logic sys_rstn,
	input wire logic req,
	input wire logic we,
	input wire logic full32,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic ack,
	input wire logic cmd_valid,
	input wire fpsc_pkg::fpsc_op_e cmd_op,
	input wire logic [3:0] cmd_block,
	input wire logic ready_flag,
	input wire logic read_ok
);
	import fpsc_pkg::*;
	logic dev_rstn;
	logic [15:0] run_ff, nxt_run, low_ff, nxt_low;
	assign dev_rstn = rstn & sys_rstn;
	// Cycles since device reset, and length of the recovery pulse
	always_comb begin
		nxt_run = (run_ff == 16'hFFFF) ? run_ff : run_ff + 16'h1;
		nxt_low = sys_rstn ? 16'h0 : low_ff + 16'h1;
	end
	// Separate resets: the pulse counter must survive the device reset
	always_ff @(posedge clock or negedge dev_rstn) begin
		if (!dev_rstn) run_ff <= 16'h0;
		else run_ff <= nxt_run;
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) low_ff <= 16'h0;
		else low_ff <= nxt_low;
	end
	//////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!dev_rstn);
	a_ack_after_req: assert property (req |=> ack) else $error("ack missing");
	a_ack_has_cause: assert property (ack |-> $past(req)) else $error("stray ack");
	a_reset_ready: assert property (disable iff (!rstn)
		!sys_rstn |-> ready_flag && !read_ok) else $error("ready or read flag wrong in reset");
	a_recover_len: assert property (disable iff (!rstn)
		$rose(sys_rstn) |-> low_ff == RECOVER) else $error("recovery pulse length wrong");
	a_read_early: assert property (read_ok |-> run_ff >= READ_WAIT - 1)
		else $error("reads allowed too soon");
	a_read_late: assert property (run_ff >= READ_WAIT + 2 |-> read_ok)
		else $error("reads never allowed");
	a_busy_cause: assert property ($fell(ready_flag) |-> $past(cmd_valid))
		else $error("busy without command");
	a_sec_unused: assert property (req && !we && addr == SEC_ENABLE_OFS |=>
		rdata[31:1] == 31'h0) else $error("security register spare bits set");
	a_status_bits: assert property (req && !we && addr == PROTECT_STATUS_OFS |=>
		rdata[31:26] == 6'h0 && rdata[15:1] == 15'h0 && rdata[0] == $past(ready_flag))
		else $error("status word wrong");
	// Main scenarios
	c_key: cover property (req && we && full32 && wdata == SEC_KEY);
	c_busy: cover property ($fell(ready_flag));
	c_recover: cover property ($rose(sys_rstn));
endmodule : fpsc_sva

// ### sim/fpsc_tb_top.sv
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module fpsc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fpsc_pkg::*;
	logic clock = 0, rstn = 0, stby = 0, op_done = 0, op_fail = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata_a, v;
	logic [1:0] bresp, rresp, r;
	logic [9:0] pinit = 10'h2A5;
	logic awready, wready, bvalid, arready, rvalid, op_start, sec_act, dbg_blk, refused;
	logic trc_blk, lockup;
	logic [3:0] oblk;
	fpsc_op_e kind;
	int fails = 0, compares = 0, nst = 0, nref = 0, cyc = 0;
	fpsc_if bus_if();
	//////////////////////////////////////////////////////////////////////////////
	fpsc_host #(.RECOVER(20)) fpsc_host_inst (.clock(clock), .rstn(rstn), .bus(bus_if.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata_a), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	fpsc_device #(.READ_WAIT(30)) fpsc_device_inst (.clock(clock), .rstn(rstn), .bus(bus_if.dev),
		.standby_release(stby), .prot_init(pinit), .op_done(op_done), .op_fail(op_fail),
		.op_start(op_start), .op_kind(kind), .op_block(oblk), .security_active(sec_act),
		.debug_block(dbg_blk), .trace_block(trc_blk), .cmd_refused(refused),
		.cmd_lockup(lockup));
	fpsc_sva #(.READ_WAIT(30), .RECOVER(20)) fpsc_sva_inst (.clock(clock), .rstn(rstn),
		.sys_rstn(bus_if.sys_rstn), .req(bus_if.req), .we(bus_if.we), .full32(bus_if.full32),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack),
		.cmd_valid(bus_if.cmd_valid), .cmd_op(bus_if.cmd_op), .cmd_block(bus_if.cmd_block),
		.ready_flag(bus_if.ready_flag), .read_ok(bus_if.read_ok));
	//////////////////////////////////////////////////////////////////////////////
	// Clock, pulse counters and hang guard
	always #4 clock = ~clock;
	always @(posedge clock) begin
		if (op_start === 1'b1) nst++;
		if (refused === 1'b1) nref++;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	// Bus tasks: bready and rready rise only after the request is taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		@(posedge clock);
		while (awready !== 1'b1 || wready !== 1'b1) @(posedge clock);
		awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b1;
		while (bvalid !== 1'b1) @(posedge clock);
		r = bresp;
		bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		araddr <= a; arvalid <= 1'b1;
		@(posedge clock);
		while (arready !== 1'b1) @(posedge clock);
		arvalid <= 1'b0; rready <= 1'b1;
		while (rvalid !== 1'b1) @(posedge clock);
		d = rdata_a; rs = rresp; rready <= 1'b0;
	endtask : axr
	task automatic st(input logic [31:0] e);
		axr(H_STATUS_OFS, v, r);
		`CHK(v, e)
	endtask : st
	// Device access through the controller, waits for the access to finish
	task automatic dacc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] c);
		axw(H_ADDR_OFS, {24'h0, a});
		axw(H_WDATA_OFS, d);
		axw(H_CTRL_OFS, {28'h0, c});
		v = 32'h1;
		while (v[0] !== 1'b0) axr(H_STATUS_OFS, v, r);
	endtask : dacc
	task automatic dchk(input logic [7:0] a, input logic [31:0] e);
		dacc(a, 32'h0, 4'h1);
		axr(H_RDATA_OFS, v, r);
		`CHK(v, e)
	endtask : dchk
	task automatic cmd(input fpsc_op_e op, input logic [3:0] b);
		axw(H_CMD_OFS, {22'h0, op, 4'h0, b});
		repeat (3) @(posedge clock);
	endtask : cmd
	task automatic fin(input logic f);
		op_done <= 1'b1; op_fail <= f;
		@(posedge clock);
		op_done <= 1'b0; op_fail <= 1'b0;
		@(posedge clock);
	endtask : fin
	task automatic report_and_stop();
		if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	//////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		st(32'h2);
		v = 32'h0;
		while (v[3] !== 1'b1) axr(H_STATUS_OFS, v, r);
		dchk(PROTECT_STATUS_OFS, {6'h0, 10'h2A5, 15'h0, 1'b1});
		dchk(8'h24, 32'h0);
		dchk(SEC_ENABLE_OFS, 32'h1);
		dacc(SEC_ENABLE_OFS, 32'h0, 4'h7);
		dchk(SEC_ENABLE_OFS, 32'h1);
		dacc(SEC_ENABLE_OFS, 32'h0, 4'hB);
		dchk(SEC_ENABLE_OFS, 32'h1);
		dacc(SEC_ENABLE_OFS, 32'hFFFFFFFE, 4'hF);
		dchk(SEC_ENABLE_OFS, 32'h0);
		stby <= 1'b1;
		@(posedge clock);
		stby <= 1'b0;
		dchk(SEC_ENABLE_OFS, 32'h1);
		// A key followed by data after the window has closed leaves the bit alone
		dacc(SEC_ENABLE_OFS, SEC_KEY, 4'h7);
		repeat (12) @(posedge clock);
		dacc(SEC_ENABLE_OFS, 32'h0, 4'h7);
		dchk(SEC_ENABLE_OFS, 32'h1);
		cmd(FPSC_OP_PROG, 4'h0);
		`CHK(nref, 1)
		cmd(FPSC_OP_PROG, 4'h1);
		st(32'h8);
		cmd(FPSC_OP_ERASE, 4'h1);
		st(32'hC);
		`CHK(lockup, 1'b0)
		axw(H_STATUS_OFS, 32'h4);
		fin(1'b0);
		st(32'hA);
		cmd(FPSC_OP_PROT_PROG, 4'h1);
		fin(1'b0);
		dacc(PROTECT_STATUS_OFS, 32'h0, 4'h7);
		dchk(PROTECT_STATUS_OFS, {6'h0, 10'h2A7, 15'h0, 1'b1});
		cmd(FPSC_OP_ERASE, 4'h3);
		fin(1'b0);
		`CHK(nst, 3)
		`CHK(kind, FPSC_OP_ERASE)
		`CHK(oblk, 4'h3)
		cmd(FPSC_OP_PROG, 4'h3);
		fin(1'b1);
		st(32'h8);
		pinit <= 10'h3FF;
		axw(H_RESET_OFS, 32'h1);
		st(32'h12);
		v = 32'h10;
		while (v[4] !== 1'b0 || v[3] !== 1'b1) axr(H_STATUS_OFS, v, r);
		dchk(PROTECT_STATUS_OFS, {6'h0, 10'h3FF, 15'h0, 1'b1});
		`CHK(sec_act, 1'b1)
		`CHK(dbg_blk, 1'b1)
		`CHK(trc_blk, 1'b1)
		cmd(FPSC_OP_PROT_PROG, 4'h1);
		`CHK(nref, 2)
		cmd(FPSC_OP_PROT_ERASE, 4'h0);
		fin(1'b0);
		dchk(PROTECT_STATUS_OFS, 32'h1);
		`CHK(sec_act, 1'b0)
		`CHK(dbg_blk, 1'b0)
		axr(8'h1C, v, r);
		`CHK(r, RESP_SLVERR)
		axw(8'h1C, 32'hFFFFFFFF);
		`CHK(r, RESP_SLVERR)
		report_and_stop();
	end
endmodule : fpsc_tb_top
